// ===== common/i2c_tx_pkg.sv
// Constants, field layout and carrier types of the I2C transmit channel
package i2c_tx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses on a 32-bit Avalon-MM slave)
  localparam int          ADDR_W          = 5;
  localparam int          BUS_W           = 32;
  localparam logic [2:0]  IDX_MODE        = 3'h0;  // serial_mode_register, 0x00
  localparam logic [2:0]  IDX_CTRL        = 3'h1;  // 0x04
  localparam logic [2:0]  IDX_DATA        = 3'h2;  // serial_data_register, 0x08
  localparam logic [2:0]  IDX_STATUS      = 3'h3;  // 0x0C
  localparam logic [2:0]  IDX_MASK        = 3'h4;  // 0x10

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int          MODE_SRC_BIT    = 0;     // Interrupt source select
  localparam int          MODE_MD_LSB     = 1;     // channel_mode_field [2:1]
  localparam int          CTRL_START_BIT  = 0;     // Write 1: start condition
  localparam int          CTRL_STOP_BIT   = 1;     // Write 1: stop after last byte
  localparam int          CTRL_DIR_LSB    = 14;    // transfer_direction_field [15:14]
  localparam int          DATA_DAT_LSB    = 0;     // Transmit byte [7:0]
  localparam int          DATA_DIV_LSB    = 9;     // baud_divider_field [15:9]
  localparam int          DIV_W           = 7;
  localparam int          ST_XFER_END     = 0;     // Sticky, write 1 to clear
  localparam int          ST_NACK         = 1;     // Sticky, write 1 to clear
  localparam int          ST_ACK_ERR      = 8;     // ack_error_flag, per byte
  localparam int          ST_BUSY         = 9;
  localparam int          ST_HELD         = 10;
  localparam int          ST_ADDR_DONE    = 11;

  ////////////////////////////////////////////////////////////////////////////
  // Encodings and reset values
  localparam logic [1:0]  MD_SIMPLE_I2C   = 2'h2;
  localparam logic [1:0]  DIR_TX_ONLY     = 2'h2;
  localparam logic [DIV_W-1:0] DIV_RST    = 7'h01;
  localparam int          FRAME_BITS      = 8;
  localparam logic [3:0]  ACK_SLOT        = 4'h8;  // Ninth bit slot

  typedef struct packed {
    logic [1:0] md;
    logic       src;
  } mode_cfg_t;

  typedef struct packed {
    logic nack;
    logic xfer_end;
  } events_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } line_t;

endpackage

// ===== rtl/pin_sync3.sv
// Three-stage input synchroniser with agreement filter for bus pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync3 #(
  parameter int              WIDTH   = 2,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input  wire logic             clk,   // System clock
  input  wire logic             rst,   // Synchronous reset, active high
  input  wire logic [WIDTH-1:0] d,     // Asynchronous pin levels
  output logic      [WIDTH-1:0] q      // Filtered levels
);

  logic [WIDTH-1:0] ff1_reg;
  logic [WIDTH-1:0] ff2_reg;
  logic [WIDTH-1:0] ff3_reg;
  logic [WIDTH-1:0] q_reg;
  logic [WIDTH-1:0] q_next;

  // Stage one feeds stage two only; a level counts once two and three agree
  always_comb begin
    q_next = (ff3_reg & ~(ff2_reg ^ ff3_reg)) | (q_reg & (ff2_reg ^ ff3_reg));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ff1_reg <= RST_VAL;
      ff2_reg <= RST_VAL;
      ff3_reg <= RST_VAL;
      q_reg   <= RST_VAL;
    end else begin
      ff1_reg <= d;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      q_reg   <= q_next;
    end
  end

  assign q = q_reg;

endmodule
`default_nettype wire

// ===== rtl/baud_tick.sv
// Phase tick generator dividing the channel operation clock
`timescale 1ns/10ps
`default_nettype none
module baud_tick
  import i2c_tx_pkg::*;
#(
  parameter int W = DIV_W
) (
  input  wire logic         clk,      // Channel operation clock
  input  wire logic         rst,      // Synchronous reset, active high
  input  wire logic         restart,  // Hold count at zero
  input  wire logic [W-1:0] div,      // Divider setting
  output logic              tick      // One-cycle phase pulse
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic [W-1:0] limit;

  // A zero setting would give a phase of one cycle; treated as one instead
  always_comb begin
    limit    = (div == '0) ? W'(1) : div;
    tick     = !restart && (cnt_reg == limit);
    cnt_next = (restart || tick) ? '0 : W'(cnt_reg + W'(1));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/i2c_tx_channel.sv
// Simplified I2C transmit channel with Avalon-MM register slave
// Function
// - Data bytes go out only after a start and address byte.
// - After the last byte a stop condition is made and bus released.
// - Each byte is reported only by the transfer-end interrupt; here a NACK also raises its own interrupt.
// - A missing acknowledge is recorded in the acknowledge-error flag.
// - Frame is 8 bits MSB first, no parity, then one ACK slot.
// - Data line is not inverted and idles high.
// - Acknowledge-error flag reads 0 on ACK and 1 on NACK per byte.
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module i2c_tx_channel
  import i2c_tx_pkg::*;
(
  input  wire logic              clk,          // Channel operation clock, 50 MHz
  input  wire logic              rst,          // Synchronous reset, active high
  input  wire logic [ADDR_W-1:0] address,      // Byte address
  input  wire logic              read,         // Read request
  input  wire logic              write,        // Write request
  input  wire logic [BUS_W-1:0]  writedata,    // Write data
  input  wire logic [3:0]        byteenable,   // Write byte lanes
  output logic      [BUS_W-1:0]  readdata,     // Read data, registered
  output logic                   waitrequest,  // Stall request
  input  wire logic              scl_in,       // Clock line level
  output logic                   scl_out,      // Clock line drive value
  output logic                   scl_oe,       // Clock line pulled low
  input  wire logic              sda_in,       // Data line level
  output logic                   sda_out,      // Data line drive value
  output logic                   sda_oe,       // Data line pulled low
  output logic                   irq           // Level interrupt
);

  typedef enum {
    S_IDLE, S_START_A, S_START_B, S_HELD, S_BIT_LOW, S_BIT_HIGH,
    S_STOP_A, S_STOP_B, S_STOP_C
  } state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  mode_cfg_t        mode_reg,      mode_next;
  logic [1:0]       dir_reg,       dir_next;
  logic [7:0]       dat_reg,       dat_next;
  logic [DIV_W-1:0] div_reg,       div_next;
  events_t          status_reg,    status_next;
  events_t          mask_reg,      mask_next;
  logic             ack_reg,       ack_next;
  logic [BUS_W-1:0] rdata_reg,     rdata_next;
  logic             start_req_reg, start_req_next;
  logic             stop_req_reg,  stop_req_next;
  logic             load_req_reg,  load_req_next;

  ////////////////////////////////////////////////////////////////////////////
  // Line state
  state_t           state_reg,     state_next;
  logic [7:0]       shift_reg,     shift_next;
  logic [3:0]       bit_reg,       bit_next;
  line_t            rel_reg,       rel_next;   // 1 = line released
  logic             ack_err_reg,   ack_err_next;
  logic             addr_done_reg, addr_done_next;
  events_t          ev;

  logic             req;
  logic             take;
  logic             en;
  logic             busy;
  logic             held;
  logic [2:0]       idx;
  logic             hit;
  logic             restart;
  logic             tick;
  logic [1:0]       pins_s;
  line_t            line_s;

  assign req  = read || write;
  assign take = req && !ack_reg;
  assign idx  = address[4:2];
  assign hit  = (idx <= IDX_MASK);
  assign en   = (mode_reg.md == MD_SIMPLE_I2C) && (dir_reg == DIR_TX_ONLY);
  assign busy = (state_reg == S_BIT_LOW) || (state_reg == S_BIT_HIGH);
  assign held = (state_reg != S_IDLE);
  assign line_s = line_t'(pins_s);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and phase timing

  pin_sync3 #(
    .WIDTH   (2),
    .RST_VAL (2'h3)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({scl_in, sda_in}),
    .q   (pins_s)
  );

  // Stretching: the high phase is not timed until the slave lets clock rise
  assign restart = (state_reg == S_IDLE) || (state_reg == S_HELD) ||
                   ((state_reg == S_BIT_HIGH || state_reg == S_STOP_B) && !line_s.scl);

  baud_tick #(
    .W (DIV_W)
  ) u_tick (
    .clk     (clk),
    .rst     (rst),
    .restart (restart),
    .div     (div_reg),
    .tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, answer at the second edge of a request

  always_comb begin
    mode_next      = mode_reg;
    dir_next       = dir_reg;
    dat_next       = dat_reg;
    div_next       = div_reg;
    mask_next      = mask_reg;
    rdata_next     = rdata_reg;
    ack_next       = take;
    start_req_next = start_req_reg;
    stop_req_next  = stop_req_reg;
    load_req_next  = load_req_reg;
    status_next    = status_reg;
    // Writes commit at the edge that ends the wait state, as the master sees it
    if (write && ack_reg && hit) begin
      unique case (idx)
        IDX_MODE: begin
          // Mode is frozen while the bus is held
          if (!held && byteenable[0]) begin
            mode_next.src = writedata[MODE_SRC_BIT];
            mode_next.md  = writedata[MODE_MD_LSB +: 2];
          end
        end
        IDX_CTRL: begin
          if (byteenable[0] && writedata[CTRL_START_BIT] && !held && en) begin
            start_req_next = 1'b1;
          end
          if (byteenable[0] && writedata[CTRL_STOP_BIT] && held) begin
            stop_req_next = 1'b1;
          end
          if (byteenable[1] && !busy) begin
            dir_next = writedata[CTRL_DIR_LSB +: 2];
          end
        end
        IDX_DATA: begin
          if (byteenable[1] && !busy) begin
            div_next = writedata[DATA_DIV_LSB +: DIV_W];
          end
          // Byte accepted only once the bus is held and no frame runs
          if (byteenable[0] && en && held && !busy && !load_req_reg) begin
            dat_next      = writedata[DATA_DAT_LSB +: 8];
            load_req_next = 1'b1;
          end
        end
        IDX_STATUS: begin
          if (byteenable[0]) begin
            status_next.xfer_end = status_reg.xfer_end & ~writedata[ST_XFER_END];
            status_next.nack     = status_reg.nack & ~writedata[ST_NACK];
          end
        end
        IDX_MASK: begin
          if (byteenable[0]) begin
            mask_next.xfer_end = writedata[ST_XFER_END];
            mask_next.nack     = writedata[ST_NACK];
          end
        end
        default: begin
        end
      endcase
    end
    // Hardware set wins over a clear in the same cycle
    status_next = status_next | ev;
    if (state_reg == S_START_A) begin
      start_req_next = 1'b0;
    end
    if (state_reg == S_STOP_A) begin
      stop_req_next = 1'b0;
    end
    if (state_reg == S_BIT_LOW) begin
      load_req_next = 1'b0;
    end
    if (take && read) begin
      rdata_next = '0;
      unique case (idx)
        IDX_MODE: begin
          rdata_next[MODE_SRC_BIT]     = mode_reg.src;
          rdata_next[MODE_MD_LSB +: 2] = mode_reg.md;
        end
        IDX_CTRL: begin
          rdata_next[CTRL_DIR_LSB +: 2] = dir_reg;
        end
        IDX_DATA: begin
          rdata_next[DATA_DAT_LSB +: 8]     = dat_reg;
          rdata_next[DATA_DIV_LSB +: DIV_W] = div_reg;
        end
        IDX_STATUS: begin
          rdata_next[ST_XFER_END]  = status_reg.xfer_end;
          rdata_next[ST_NACK]      = status_reg.nack;
          rdata_next[ST_ACK_ERR]   = ack_err_reg;
          rdata_next[ST_BUSY]      = busy || load_req_reg;
          rdata_next[ST_HELD]      = held;
          rdata_next[ST_ADDR_DONE] = addr_done_reg;
        end
        IDX_MASK: begin
          rdata_next[ST_XFER_END] = mask_reg.xfer_end;
          rdata_next[ST_NACK]     = mask_reg.nack;
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg      <= '0;
      dir_reg       <= '0;
      dat_reg       <= '0;
      div_reg       <= DIV_RST;
      status_reg    <= '0;
      mask_reg      <= '0;
      ack_reg       <= 1'b0;
      rdata_reg     <= '0;
      start_req_reg <= 1'b0;
      stop_req_reg  <= 1'b0;
      load_req_reg  <= 1'b0;
    end else begin
      mode_reg      <= mode_next;
      dir_reg       <= dir_next;
      dat_reg       <= dat_next;
      div_reg       <= div_next;
      status_reg    <= status_next;
      mask_reg      <= mask_next;
      ack_reg       <= ack_next;
      rdata_reg     <= rdata_next;
      start_req_reg <= start_req_next;
      stop_req_reg  <= stop_req_next;
      load_req_reg  <= load_req_next;
    end
  end

  assign waitrequest = req && !ack_reg;
  assign readdata    = rdata_reg;
  // Source select is ignored: the transfer-end and NACK events both interrupt when unmasked
  assign irq         = |(status_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Line sequencer

  always_comb begin
    state_next     = state_reg;
    shift_next     = shift_reg;
    bit_next       = bit_reg;
    rel_next       = rel_reg;
    ack_err_next   = ack_err_reg;
    addr_done_next = addr_done_reg;
    ev             = '0;
    unique case (state_reg)
      S_IDLE: begin
        rel_next = '{scl: 1'b1, sda: 1'b1};
        if (start_req_reg) begin
          rel_next.sda   = 1'b0;
          addr_done_next = 1'b0;
          ack_err_next   = 1'b0;
          state_next     = S_START_A;
        end
      end
      S_START_A: begin
        if (tick) begin
          rel_next.scl = 1'b0;
          state_next   = S_START_B;
        end
      end
      S_START_B: begin
        if (tick) begin
          state_next = S_HELD;
        end
      end
      S_HELD: begin
        // Pending byte first so stop follows only the last one
        if (load_req_reg) begin
          shift_next = dat_reg;
          bit_next   = '0;
          state_next = S_BIT_LOW;
        end else if (stop_req_reg) begin
          state_next = S_STOP_A;
        end
      end
      S_BIT_LOW: begin
        // Data moves one cycle after the clock has fallen
        rel_next.sda = (bit_reg == ACK_SLOT) ? 1'b1 : shift_reg[7];
        if (tick) begin
          rel_next.scl = 1'b1;
          state_next   = S_BIT_HIGH;
        end
      end
      S_BIT_HIGH: begin
        if (tick) begin
          rel_next.scl = 1'b0;
          if (bit_reg == ACK_SLOT) begin
            ack_err_next   = line_s.sda;
            addr_done_next = 1'b1;
            ev.xfer_end    = 1'b1;
            ev.nack        = line_s.sda;
            state_next     = S_HELD;
          end else begin
            shift_next = {shift_reg[6:0], 1'b0};
            bit_next   = 4'(bit_reg + 4'h1);
            state_next = S_BIT_LOW;
          end
        end
      end
      S_STOP_A: begin
        rel_next.sda = 1'b0;
        if (tick) begin
          rel_next.scl = 1'b1;
          state_next   = S_STOP_B;
        end
      end
      S_STOP_B: begin
        if (tick) begin
          rel_next.sda = 1'b1;
          state_next   = S_STOP_C;
        end
      end
      S_STOP_C: begin
        // Bus free time before a new start can be made
        if (tick) begin
          state_next = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg     <= S_IDLE;
      shift_reg     <= '0;
      bit_reg       <= '0;
      rel_reg       <= '{scl: 1'b1, sda: 1'b1};
      ack_err_reg   <= 1'b0;
      addr_done_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      shift_reg     <= shift_next;
      bit_reg       <= bit_next;
      rel_reg       <= rel_next;
      ack_err_reg   <= ack_err_next;
      addr_done_reg <= addr_done_next;
    end
  end

  // Open-drain: only ever pull low, never drive high
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = !rel_reg.scl;
  assign sda_oe  = !rel_reg.sda;

endmodule
`default_nettype wire

// ===== sim/i2c_tx_channel_props.sv
// Concurrent checks on the ports of the I2C transmit channel
`timescale 1ns/10ps
`default_nettype none
module i2c_tx_channel_props
  import i2c_tx_pkg::*;
(
  input wire logic             clk,          // Channel clock
  input wire logic             rst,          // Synchronous reset
  input wire logic             read,         // Bus read request
  input wire logic             write,        // Bus write request
  input wire logic [BUS_W-1:0] readdata,     // Bus read data
  input wire logic             waitrequest,  // Bus stall
  input wire logic             scl_out,      // Clock drive value
  input wire logic             scl_oe,       // Clock pulled low
  input wire logic             sda_out,      // Data drive value
  input wire logic             sda_oe,       // Data pulled low
  input wire logic             irq           // Level interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  chk_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer not after one wait state");
  chk_idle_wait: assert property (!read && !write |-> !waitrequest)
    else $error("stall raised without a request");
  chk_rd_hold: assert property (!read |=> $stable(readdata))
    else $error("read data moved without a read");
  chk_drive_zero: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("open-drain drive value not low");
  chk_reset_idle: assert property ($fell(rst) |-> !scl_oe && !sda_oe && !irq)
    else $error("lines or interrupt not idle after reset");
  // Data only moves in the low phase, so it must hold across a release
  chk_sda_stable: assert property ($fell(scl_oe) |-> $stable(sda_oe) [*2])
    else $error("data line moved while clock high");
  chk_scl_phase: assert property ($rose(scl_oe) |-> scl_oe [*2])
    else $error("clock low phase shorter than two cycles");
  chk_stop_free: assert property ($fell(sda_oe) && !scl_oe |-> (!scl_oe && !sda_oe) [*4])
    else $error("bus not released after stop");
  chk_start_clk: assert property ($rose(sda_oe) && !scl_oe |-> ##[1:40] scl_oe)
    else $error("start not followed by clock low");
  chk_irq_cause: assert property ($rose(irq) |-> scl_oe || $past(write))
    else $error("interrupt rose outside acknowledge end or write");
endmodule
bind i2c_tx_channel i2c_tx_channel_props chk_u (
  .clk(clk), .rst(rst), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq)
);
`default_nettype wire

// ===== sim/i2c_slave_model.sv
// Behavioural I2C slave receiver on the two-wire bus
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_model (
  input  wire logic  clk,      // Sampling clock
  input  wire logic  scl,      // Resolved clock line
  input  wire logic  sda,      // Resolved data line
  input  wire logic  nack,     // Answer not-acknowledge
  input  wire logic  stretch,  // Hold clock low after each fall
  output logic       scl_oe,   // Pull clock line low
  output logic       sda_oe,   // Pull data line low
  output logic [7:0] rx_byte,  // Last byte taken
  output int         n_rx,     // Bytes since last start
  output logic       stopped   // Stop seen since last start
);
  logic       scl_d;
  logic       sda_d;
  logic [7:0] sh;
  int         bits;
  int         hold;
  initial begin
    {scl_d, sda_d, scl_oe, sda_oe, stopped} = 5'h18;
    {sh, rx_byte} = 16'h0000;
    {bits, hold, n_rx} = {32'd0, 32'd0, 32'd0};
  end
  always @(posedge clk) begin
    scl_d <= scl;
    sda_d <= sda;
    if (scl && scl_d && sda_d && !sda) begin
      bits <= 0;
      n_rx <= 0;
      stopped <= 1'b0;
    end
    if (scl && scl_d && !sda_d && sda) stopped <= 1'b1;
    if (scl && !scl_d) begin
      if (bits < 8) sh <= {sh[6:0], sda};
      bits <= bits + 1;
    end
    if (hold == 1) scl_oe <= 1'b0;
    if (hold > 0) hold <= hold - 1;
    if (!scl && scl_d) begin
      // Slow partner: master must wait for the line, not its own count
      scl_oe <= stretch;
      hold <= 20;
      if (bits == 8) begin
        sda_oe <= !nack;
        rx_byte <= sh;
        n_rx <= n_rx + 1;
      end
      if (bits == 9) begin
        sda_oe <= 1'b0;
        bits <= 0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the I2C transmit channel
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb;
  import i2c_tx_pkg::*;
  logic              clk, rst, read, write, waitrequest, irq;
  logic [ADDR_W-1:0] address;
  logic [BUS_W-1:0]  writedata, readdata, q;
  logic [3:0]        byteenable;
  logic              scl_oe, sda_oe, s_scl_oe, s_sda_oe, nack, stretch, stopped;
  logic [7:0]        rx_byte;
  int                n_rx, n_mismatch, n_checks;
  // Pull-ups on both lines: released means high
  wire logic         scl = !(scl_oe || s_scl_oe);
  wire logic         sda = !(sda_oe || s_sda_oe);

  i2c_tx_channel dut_u (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .scl_in(scl), .scl_out(),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .irq(irq));
  i2c_slave_model slave_u (.clk(clk), .scl(scl), .sda(sda), .nack(nack),
    .stretch(stretch), .scl_oe(s_scl_oe), .sda_oe(s_sda_oe), .rx_byte(rx_byte),
    .n_rx(n_rx), .stopped(stopped));

  ////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic wr, input logic [2:0] idx, input logic [BUS_W-1:0] d);
    @(posedge clk);
    address <= {idx, 2'b00};
    writedata <= d;
    write <= wr;
    read <= !wr;
    // Request stands until waitrequest is seen low at a rising edge
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    `CHK(waitrequest, 1'b0)
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    // Let that edge's updates settle before callers look at outputs
    @(negedge clk);
  endtask

  task automatic wait_st(input int b, input logic v);
    for (int i = 0; i < 200; i++) begin
      bus(1'b0, IDX_STATUS, 32'h0);
      if (q[b] === v) break;
    end
    `CHK(q[b], v)
  endtask

  // Divider 3 gives a 240 ns bus clock period: 4-cycle low phase, 8-cycle high phase through the pin synchroniser
  task automatic send(input logic [7:0] b, input logic nk);
    nack <= nk;
    bus(1'b1, IDX_DATA, 32'h0000_0600 | 32'(b));
    for (int i = 0; i < 2000 && irq !== 1'b1; i++) @(negedge clk);
    `CHK(irq, 1'b1)
    `CHK(rx_byte, b)
    bus(1'b0, IDX_STATUS, 32'h0);
    `CHK(q[ST_ACK_ERR], nk)
    `CHK(q[ST_NACK], nk)
    `CHK(q[ST_XFER_END], 1'b1)
    bus(1'b1, IDX_STATUS, 32'h0000_0003);
    `CHK(irq, 1'b0)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    `CHK({irq, scl_oe, sda_oe}, 3'h0)
    bus(1'b0, IDX_STATUS, 32'h0);
    `CHK(q[1:0], 2'h0)
    bus(1'b0, IDX_MASK, 32'h0);
    `CHK(q[1:0], 2'h0)
    bus(1'b0, IDX_DATA, 32'h0);
    `CHK(q[15:9], DIV_RST)
    bus(1'b0, 3'h5, 32'h0);
    `CHK(q, 32'h0000_0000)
  endtask

  task automatic t_config;
    bus(1'b1, IDX_MODE, 32'(MD_SIMPLE_I2C) << MODE_MD_LSB);
    bus(1'b1, IDX_CTRL, 32'(DIR_TX_ONLY) << CTRL_DIR_LSB);
    bus(1'b1, IDX_MASK, 32'h0000_0003);
    bus(1'b1, IDX_DATA, 32'h0000_06A4);
    repeat (100) @(posedge clk);
    `CHK(n_rx, 0)
  endtask

  task automatic t_frame;
    bus(1'b1, IDX_CTRL, 32'h0000_8001);
    wait_st(ST_HELD, 1'b1);
    bus(1'b1, IDX_MODE, 32'h0);
    bus(1'b0, IDX_MODE, 32'h0);
    `CHK(q[MODE_MD_LSB +: 2], MD_SIMPLE_I2C)
    send(8'hA4, 1'b0);
    stretch <= 1'b1;
    send(8'h5B, 1'b0);
    stretch <= 1'b0;
    send(8'h3C, 1'b1);
    `CHK(n_rx, 3)
  endtask

  task automatic t_mask_stop;
    bus(1'b1, IDX_MASK, 32'h0);
    bus(1'b1, IDX_DATA, 32'h0000_0681);
    wait_st(ST_XFER_END, 1'b1);
    `CHK(irq, 1'b0)
    bus(1'b1, IDX_MASK, 32'h0000_0001);
    `CHK(irq, 1'b1)
    bus(1'b1, IDX_STATUS, 32'h0000_0003);
    `CHK(irq, 1'b0)
    bus(1'b1, IDX_CTRL, 32'h0000_8002);
    wait_st(ST_HELD, 1'b0);
    `CHK(stopped, 1'b1)
    `CHK({scl_oe, sda_oe}, 2'h0)
    `CHK(n_rx, 4)
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    final_report;
  end
  initial begin
    {rst, read, write, nack, stretch} = 5'h10;
    {address, writedata, byteenable} = '0;
    byteenable = 4'hF;
    {n_mismatch, n_checks} = {32'd0, 32'd0};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_config;
    t_frame;
    t_mask_stop;
    final_report;
  end
endmodule
`default_nettype wire
